// *** rtl/led_head_driver.v ***
// Design decisions made here: the register addresses and the AXI4-Lite slave port.
`include "shift_latch_regs.vh"
`timescale 1ns/1ps
`default_nettype none
module led_head_driver #(
    parameter WIDTH = 32 // stages and outputs
) (
    input wire CLK, // system clock, 40 MHz
    input wire RST, // synchronous reset, active high
    input wire SHIFT_CLK, // shift clock pin
    input wire SERIAL_DATA_IN, // serial data pin
    input wire LATCH_N, // latch control pin, low is transparent
    input wire BLANKING_ENABLE, // blanking enable pin
    input wire STROBE, // strobe pin, low enables
    input wire LAMP_CHECK_PIN, // lamp check pin
    input wire PIN_SELECT, // 1 = pins drive, 0 = registers drive
    output reg SERIAL_DATA_OUT, // cascade output
    output reg [WIDTH-1:0] DRIVER_OUTPUTS_O, // open-drain output level
    output reg [WIDTH-1:0] DRIVER_OUTPUTS_OE, // high while pulling low
    input wire [3:0] S_AXI_AWADDR, // write address
    input wire S_AXI_AWVALID, // write address valid
    output wire S_AXI_AWREADY, // write address ready
    input wire [31:0] S_AXI_WDATA, // write data
    input wire [3:0] S_AXI_WSTRB, // write strobes
    input wire S_AXI_WVALID, // write data valid
    output wire S_AXI_WREADY, // write data ready
    output wire [1:0] S_AXI_BRESP, // write response
    output wire S_AXI_BVALID, // write response valid
    input wire S_AXI_BREADY, // write response ready
    input wire [3:0] S_AXI_ARADDR, // read address
    input wire S_AXI_ARVALID, // read address valid
    output wire S_AXI_ARREADY, // read address ready
    output wire [31:0] S_AXI_RDATA, // read data
    output wire [1:0] S_AXI_RRESP, // read response
    output wire S_AXI_RVALID, // read valid
    input wire S_AXI_RREADY // read ready
);
    localparam HALF = `SHIFT_HALF_CYCLES;
    wire sclk_s;
    wire sin_s;
    wire latch_s;
    wire blank_s;
    wire strobe_s;
    wire lamp_s;
    pin_sync u_sclk (.clk(CLK), .rst(RST), .pin_in(SHIFT_CLK),
        .pin_out(sclk_s));
    pin_sync u_sin (.clk(CLK), .rst(RST), .pin_in(SERIAL_DATA_IN),
        .pin_out(sin_s));
    pin_sync u_latch (.clk(CLK), .rst(RST), .pin_in(LATCH_N),
        .pin_out(latch_s));
    pin_sync u_blank (.clk(CLK), .rst(RST), .pin_in(BLANKING_ENABLE),
        .pin_out(blank_s));
    pin_sync u_strobe (.clk(CLK), .rst(RST), .pin_in(STROBE),
        .pin_out(strobe_s));
    pin_sync u_lamp (.clk(CLK), .rst(RST), .pin_in(LAMP_CHECK_PIN),
        .pin_out(lamp_s));
    // source select is a pin too, so it is filtered like the others
    wire sel_s;
    pin_sync u_sel (.clk(CLK), .rst(RST), .pin_in(PIN_SELECT),
        .pin_out(sel_s));
    wire wr_en;
    wire [3:0] wr_addr;
    wire [31:0] wr_data;
    wire [3:0] wr_strb;
    wire rd_en;
    wire [3:0] rd_addr;
    reg [31:0] rd_data;
    reg wr_ok;
    reg rd_ok;
    axil_slave u_bus (
        .clk(CLK), .rst(RST),
        .awaddr(S_AXI_AWADDR), .awvalid(S_AXI_AWVALID),
        .awready(S_AXI_AWREADY),
        .wdata(S_AXI_WDATA), .wstrb(S_AXI_WSTRB), .wvalid(S_AXI_WVALID),
        .wready(S_AXI_WREADY),
        .bresp(S_AXI_BRESP), .bvalid(S_AXI_BVALID), .bready(S_AXI_BREADY),
        .araddr(S_AXI_ARADDR), .arvalid(S_AXI_ARVALID),
        .arready(S_AXI_ARREADY),
        .rdata(S_AXI_RDATA), .rresp(S_AXI_RRESP), .rvalid(S_AXI_RVALID),
        .rready(S_AXI_RREADY),
        .wr_en(wr_en), .wr_addr(wr_addr), .wr_data(wr_data),
        .wr_strb(wr_strb), .wr_ok(wr_ok),
        .rd_en(rd_en), .rd_addr(rd_addr), .rd_data(rd_data), .rd_ok(rd_ok)
    );
    // software control word and shift-step pacing
    reg [4:0] ctl_q;
    reg ctl_sclk_q;
    reg [7:0] pace_q;
    reg [WIDTH-1:0] shift_q;
    reg [WIDTH-1:0] latch_q;
    reg sclk_prev_q;
    wire sel_latch_n = sel_s ? latch_s : ctl_q[`CTL_LATCH_BIT];
    wire sel_blank = sel_s ? blank_s : ctl_q[`CTL_BLANK_BIT];
    wire sel_strobe = sel_s ? strobe_s : ctl_q[`CTL_STROBE_BIT];
    wire sel_lamp = sel_s ? lamp_s : ctl_q[`CTL_LAMP_BIT];
    wire sel_sin = sel_s ? sin_s : ctl_q[`CTL_SIN_BIT];
    wire sel_sclk = sel_s ? sclk_s : ctl_sclk_q;
    wire shift_rise = sel_sclk && !sclk_prev_q;
    always @* begin
        wr_ok = (wr_addr == `OFS_SHIFT_DATA) || (wr_addr == `OFS_CONTROL);
        rd_ok = (rd_addr == `OFS_SHIFT_DATA) ||
            (rd_addr == `OFS_LATCH_DATA) || (rd_addr == `OFS_CONTROL) ||
            (rd_addr == `OFS_PINS);
        case (rd_addr)
            `OFS_SHIFT_DATA: rd_data = shift_q;
            `OFS_LATCH_DATA: rd_data = latch_q;
            `OFS_CONTROL: rd_data = {27'h0000000, ctl_q};
            `OFS_PINS: rd_data = {26'h0000000, sel_sclk, sel_sin,
                sel_lamp, sel_strobe, sel_blank, sel_latch_n};
            default: rd_data = 32'h00000000;
        endcase
    end
    // writing the shift word with byte 0 enabled pulses one software
    // shift clock, stretched to the 5 MHz period so the register source obeys it
    always @(posedge CLK) begin
        if (RST) begin
            ctl_q <= `CTL_RESET;
            ctl_sclk_q <= 1'b0;
            pace_q <= 8'h00;
        end else begin
            if (wr_en && wr_addr == `OFS_CONTROL && wr_strb[0]) begin
                ctl_q <= wr_data[4:0];
            end
            if (wr_en && wr_addr == `OFS_SHIFT_DATA && wr_strb[0] &&
                    pace_q == 8'h00) begin
                ctl_sclk_q <= 1'b1;
                pace_q <= HALF[7:0] + HALF[7:0];
            end else if (pace_q != 8'h00) begin
                pace_q <= pace_q - 8'h01;
                if (pace_q == HALF[7:0]) begin
                    ctl_sclk_q <= 1'b0;
                end
            end
        end
    end
    // shift register, latch and cascade output
    always @(posedge CLK) begin
        if (RST) begin
            shift_q <= `SHIFT_RESET;
            latch_q <= `SHIFT_RESET;
            sclk_prev_q <= 1'b0;
            SERIAL_DATA_OUT <= 1'b0;
        end else begin
            sclk_prev_q <= sel_sclk;
            if (shift_rise) begin
                shift_q <= {shift_q[WIDTH-2:0], sel_sin};
                SERIAL_DATA_OUT <= shift_q[WIDTH-2];
            end
            if (!sel_latch_n) begin
                latch_q <= shift_q;
            end
        end
    end
    // output gating, registered; lamp check forces latch value to ones
    wire [WIDTH-1:0] eff_latch = (sel_lamp && !sel_strobe && sel_blank) ?
        {WIDTH{1'b1}} : latch_q;
    wire [WIDTH-1:0] on_bits = eff_latch &
        {WIDTH{sel_blank && !sel_strobe}};
    always @(posedge CLK) begin
        if (RST) begin
            DRIVER_OUTPUTS_O <= {WIDTH{1'b0}};
            DRIVER_OUTPUTS_OE <= {WIDTH{1'b0}};
        end else begin
            DRIVER_OUTPUTS_O <= {WIDTH{1'b0}};
            DRIVER_OUTPUTS_OE <= on_bits;
        end
    end
endmodule // led_head_driver
`default_nettype wire

// *** rtl/shift_latch_regs.vh ***
`ifndef SHIFT_LATCH_REGS_VH
`define SHIFT_LATCH_REGS_VH
// byte offsets of the register words
`define OFS_SHIFT_DATA 4'h0
`define OFS_LATCH_DATA 4'h4
`define OFS_CONTROL 4'h8
`define OFS_PINS 4'hc
// control word fields
`define CTL_LATCH_BIT 0
`define CTL_BLANK_BIT 1
`define CTL_STROBE_BIT 2
`define CTL_LAMP_BIT 3
`define CTL_SIN_BIT 4
// reset values
`define CTL_RESET 5'h05
`define SHIFT_RESET 32'h00000000
// timing: shortest shift clock period is 200 ns (5 MHz)
`define SHIFT_MIN_PERIOD_NS 200
`define CLK_PERIOD_NS 25
`define SHIFT_HALF_CYCLES ((`SHIFT_MIN_PERIOD_NS / 2 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define AXI_OKAY 2'h0
`define AXI_SLVERR 2'h2
`endif

// *** rtl/pin_sync.v ***
`timescale 1ns/1ps
`default_nettype none
// three-stage synchroniser; output moves once stages two and three agree
module pin_sync (
    input wire clk, // clock
    input wire rst, // synchronous reset
    input wire pin_in, // asynchronous input
    output reg pin_out // filtered level
);
    reg s1_q;
    reg s2_q;
    reg s3_q;
    always @(posedge clk) begin
        if (rst) begin
            s1_q <= 1'b0;
            s2_q <= 1'b0;
            s3_q <= 1'b0;
            pin_out <= 1'b0;
        end else begin
            s1_q <= pin_in;
            s2_q <= s1_q;
            s3_q <= s2_q;
            if (s2_q == s3_q) begin
                pin_out <= s3_q;
            end
        end
    end
endmodule // pin_sync
`default_nettype wire

// *** rtl/axil_slave.v ***
`timescale 1ns/1ps
`default_nettype none
`include "shift_latch_regs.vh"
// axi4-lite slave front end; exposes one write strobe and one read strobe
module axil_slave (
    input wire clk, // clock
    input wire rst, // synchronous reset
    input wire [3:0] awaddr, // write address
    input wire awvalid, // write address valid
    output reg awready, // write address ready
    input wire [31:0] wdata, // write data
    input wire [3:0] wstrb, // write strobes
    input wire wvalid, // write data valid
    output reg wready, // write data ready
    output reg [1:0] bresp, // write response
    output reg bvalid, // write response valid
    input wire bready, // write response ready
    input wire [3:0] araddr, // read address
    input wire arvalid, // read address valid
    output reg arready, // read address ready
    output reg [31:0] rdata, // read data
    output reg [1:0] rresp, // read response
    output reg rvalid, // read valid
    input wire rready, // read ready
    output reg wr_en, // one-cycle write strobe
    output reg [3:0] wr_addr, // write address
    output reg [31:0] wr_data, // write data
    output reg [3:0] wr_strb, // write byte enables
    input wire wr_ok, // address mapped
    output reg rd_en, // one-cycle read strobe
    output reg [3:0] rd_addr, // read address
    input wire [31:0] rd_data, // read word, valid with rd_en
    input wire rd_ok // address mapped
);
    reg aw_got_q;
    reg w_got_q;
    always @(posedge clk) begin
        if (rst) begin
            awready <= 1'b1;
            wready <= 1'b1;
            bvalid <= 1'b0;
            bresp <= `AXI_OKAY;
            aw_got_q <= 1'b0;
            w_got_q <= 1'b0;
            wr_en <= 1'b0;
            wr_addr <= 4'h0;
            wr_data <= 32'h00000000;
            wr_strb <= 4'h0;
        end else begin
            wr_en <= 1'b0;
            if (awvalid && awready) begin
                wr_addr <= awaddr;
                aw_got_q <= 1'b1;
                awready <= 1'b0;
            end
            if (wvalid && wready) begin
                wr_data <= wdata;
                wr_strb <= wstrb;
                w_got_q <= 1'b1;
                wready <= 1'b0;
            end
            if (aw_got_q && w_got_q && !bvalid && !wr_en) begin
                wr_en <= 1'b1;
            end
            if (wr_en) begin
                bvalid <= 1'b1;
                bresp <= wr_ok ? `AXI_OKAY : `AXI_SLVERR;
            end
            if (bvalid && bready) begin
                bvalid <= 1'b0;
                aw_got_q <= 1'b0;
                w_got_q <= 1'b0;
                awready <= 1'b1;
                wready <= 1'b1;
            end
        end
    end
    always @(posedge clk) begin
        if (rst) begin
            arready <= 1'b1;
            rvalid <= 1'b0;
            rdata <= 32'h00000000;
            rresp <= `AXI_OKAY;
            rd_en <= 1'b0;
            rd_addr <= 4'h0;
        end else begin
            rd_en <= 1'b0;
            if (arvalid && arready) begin
                rd_addr <= araddr;
                arready <= 1'b0;
                rd_en <= 1'b1;
            end
            if (rd_en) begin
                rvalid <= 1'b1;
                rdata <= rd_ok ? rd_data : 32'h00000000;
                rresp <= rd_ok ? `AXI_OKAY : `AXI_SLVERR;
            end
            if (rvalid && rready) begin
                rvalid <= 1'b0;
                arready <= 1'b1;
            end
        end
    end
endmodule // axil_slave
`default_nettype wire

// *** verif/led_head_driver_properties.sv ***
`timescale 1ns/1ps
`default_nettype none
module led_head_driver_properties #(
    parameter WIDTH = 32 // outputs
) (
    input wire logic CLK, // clock
    input wire logic RST, // reset
    input wire logic SHIFT_CLK, // pin
    input wire logic LATCH_N, // pin
    input wire logic BLANKING_ENABLE, // pin
    input wire logic STROBE, // pin
    input wire logic LAMP_CHECK_PIN, // pin
    input wire logic PIN_SELECT, // source
    input wire logic SERIAL_DATA_OUT, // cascade
    input wire logic [WIDTH-1:0] DRIVER_OUTPUTS_O, // level
    input wire logic [WIDTH-1:0] DRIVER_OUTPUTS_OE, // enable
    input wire logic S_AXI_AWVALID, // bus
    input wire logic S_AXI_AWREADY, // bus
    input wire logic S_AXI_WVALID, // bus
    input wire logic S_AXI_WREADY, // bus
    input wire logic S_AXI_BVALID, // bus
    input wire logic S_AXI_ARVALID, // bus
    input wire logic S_AXI_ARREADY, // bus
    input wire logic S_AXI_RVALID // bus
);
    default clocking @(posedge CLK); endclocking
    default disable iff (RST);
    a_drain_low: assert property (DRIVER_OUTPUTS_O == '0)
        else $error("driver level not low");
    a_strobe_off: assert property ((PIN_SELECT && STROBE)[*7]
        |-> DRIVER_OUTPUTS_OE == '0) else $error("on while strobe high");
    a_blank_off: assert property ((PIN_SELECT && !BLANKING_ENABLE)[*7]
        |-> DRIVER_OUTPUTS_OE == '0) else $error("on while blanked");
    a_lamp_all: assert property ((PIN_SELECT && LAMP_CHECK_PIN &&
        BLANKING_ENABLE && !STROBE)[*8] |-> &DRIVER_OUTPUTS_OE)
        else $error("lamp check not all on");
    a_sdo_quiet: assert property ((PIN_SELECT && $stable(SHIFT_CLK))[*7]
        |-> $stable(SERIAL_DATA_OUT)) else $error("cascade moved");
    a_latch_hold: assert property ((PIN_SELECT && LATCH_N &&
        BLANKING_ENABLE && !STROBE && !LAMP_CHECK_PIN)[*8]
        |=> $stable(DRIVER_OUTPUTS_OE)) else $error("latch not held");
    a_read_lat: assert property ($rose(S_AXI_RVALID)
        |-> $past(S_AXI_ARVALID && S_AXI_ARREADY, 2))
        else $error("read answer timing");
    a_write_lat: assert property ($rose(S_AXI_BVALID)
        |-> $past(S_AXI_AWVALID && S_AXI_AWREADY, 3)
        || $past(S_AXI_WVALID && S_AXI_WREADY, 3))
        else $error("write answer timing");
    c_lamp: cover property (&DRIVER_OUTPUTS_OE);
    c_sdo: cover property ($rose(SERIAL_DATA_OUT));
    c_write: cover property (S_AXI_BVALID);
endmodule // led_head_driver_properties
bind led_head_driver led_head_driver_properties #(.WIDTH(WIDTH)) u_props (
    .CLK(CLK), .RST(RST), .SHIFT_CLK(SHIFT_CLK), .LATCH_N(LATCH_N),
    .BLANKING_ENABLE(BLANKING_ENABLE), .STROBE(STROBE),
    .LAMP_CHECK_PIN(LAMP_CHECK_PIN), .PIN_SELECT(PIN_SELECT),
    .SERIAL_DATA_OUT(SERIAL_DATA_OUT), .DRIVER_OUTPUTS_O(DRIVER_OUTPUTS_O),
    .DRIVER_OUTPUTS_OE(DRIVER_OUTPUTS_OE), .S_AXI_AWVALID(S_AXI_AWVALID),
    .S_AXI_AWREADY(S_AXI_AWREADY), .S_AXI_WVALID(S_AXI_WVALID),
    .S_AXI_WREADY(S_AXI_WREADY), .S_AXI_BVALID(S_AXI_BVALID),
    .S_AXI_ARVALID(S_AXI_ARVALID), .S_AXI_ARREADY(S_AXI_ARREADY),
    .S_AXI_RVALID(S_AXI_RVALID));
`default_nettype wire

// *** verif/shift_ctrl_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module shift_ctrl_model (
    input wire logic clk, // bench clock
    input wire logic go, // send one bit
    input wire logic bit_in, // bit to send
    output logic sclk, // shift clock pin
    output logic serial_data_in, // serial data pin
    output logic busy // bit in flight
);
    initial begin
        sclk = 1'h0;
        serial_data_in = 1'h0;
        busy = 1'h0;
    end
    // five cycles per phase keeps the shift clock below 5 MHz
    always @(posedge clk) begin
        if (go && !busy) begin
            busy <= 1'h1;
            serial_data_in <= bit_in;
            repeat (5) @(posedge clk);
            sclk <= 1'h1;
            repeat (5) @(posedge clk);
            sclk <= 1'h0;
            repeat (5) @(posedge clk);
            serial_data_in <= ~bit_in; // stale data once hold is over
            busy <= 1'h0;
        end
    end
endmodule // shift_ctrl_model
`default_nettype wire

// *** verif/test_led_head_driver.sv ***
`timescale 1ns/1ps
`default_nettype none
module test_led_head_driver;
    logic clk = 0, rst = 1, ps = 1, ln = 1, be = 0, st = 1, lc = 0;
    logic go = 0, gb = 0, awv = 0, wv = 0, bre = 0, arv = 0, rre = 0;
    logic sclk, serial_data_in, busy, sdo, awr, wrd, bv, arr, rv;
    logic [31:0] o, oe, rdata, wd = 0;
    logic [3:0] aa = 0, ra = 0, ws = 4'hf;
    logic [1:0] br, rr;
    int failures = 0, check_count = 0;
    always #12.5 clk = ~clk;
    shift_ctrl_model pm (.clk(clk), .go(go), .bit_in(gb), .sclk(sclk),
        .serial_data_in(serial_data_in), .busy(busy));
    led_head_driver dut (.CLK(clk), .RST(rst), .SHIFT_CLK(sclk),
        .SERIAL_DATA_IN(serial_data_in), .LATCH_N(ln), .BLANKING_ENABLE(be), .STROBE(st),
        .LAMP_CHECK_PIN(lc), .PIN_SELECT(ps), .SERIAL_DATA_OUT(sdo),
        .DRIVER_OUTPUTS_O(o), .DRIVER_OUTPUTS_OE(oe), .S_AXI_AWADDR(aa),
        .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr), .S_AXI_WDATA(wd),
        .S_AXI_WSTRB(ws), .S_AXI_WVALID(wv), .S_AXI_WREADY(wrd),
        .S_AXI_BRESP(br), .S_AXI_BVALID(bv), .S_AXI_BREADY(bre),
        .S_AXI_ARADDR(ra), .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr),
        .S_AXI_RDATA(rdata), .S_AXI_RRESP(rr), .S_AXI_RVALID(rv),
        .S_AXI_RREADY(rre));
    task chk(input logic [31:0] g, input logic [31:0] e);
        check_count++;
        if (g !== e) begin
            failures++;
            $display("BAD %0t got %h exp %h", $time, g, e);
        end
    endtask
    task report_and_stop;
        $display("checks %0d failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    // expected enables from latch word and the three gating levels
    function automatic logic [31:0] exp_oe(input logic [31:0] q,
            input logic lamp, input logic strobe, input logic blank);
        if (!blank || strobe) begin
            return 32'h0;
        end
        return lamp ? 32'hffffffff : q;
    endfunction
    // p is {lamp, strobe, blank, latch_n}
    task pins(input logic [3:0] p);
        @(posedge clk);
        {lc, st, be, ln} <= p;
        repeat (8) @(posedge clk);
        #1;
    endtask
    task shbit(input logic b);
        @(posedge clk);
        go <= 1'h1;
        gb <= b;
        @(posedge clk);
        go <= 1'h0;
        do @(posedge clk); while (busy);
        #1;
    endtask
    task wr(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
        logic da, dw;
        @(posedge clk);
        aa <= a;
        wd <= d;
        awv <= 1'h1;
        wv <= 1'h1;
        bre <= 1'h1;
        da = 0;
        dw = 0;
        while (!(da && dw)) begin
            @(posedge clk);
            if (awr && !da) begin
                da = 1;
                awv <= 1'h0;
            end
            if (wrd && !dw) begin
                dw = 1;
                wv <= 1'h0;
            end
        end
        do @(posedge clk); while (!bv);
        bre <= 1'h0;
        r = br;
    endtask
    task rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge clk);
        ra <= a;
        arv <= 1'h1;
        rre <= 1'h1;
        do @(posedge clk); while (!arr);
        arv <= 1'h0;
        do @(posedge clk); while (!rv);
        rre <= 1'h0;
        d = rdata;
        r = rr;
    endtask
    initial begin
        #500000;
        failures++;
        report_and_stop;
    end
    initial begin
        logic [31:0] w[2], e, v;
        logic [1:0] r;
        logic b;
        void'($urandom(32'hdd587cd4));
        w[0] = 32'h80000001;
        w[1] = $urandom;
        e = 32'h0;
        repeat (4) @(posedge clk);
        rst <= 1'h0;
        repeat (6) @(posedge clk);
        #1;
        chk(oe, 32'h0);
        chk({31'h0, sdo}, 32'h0);
        rd(4'h8, v, r);
        chk(v, 32'h05);
        $display("reset test done");
        pins(4'h3);
        for (int k = 0; k < 2; k++) begin
            for (int i = 31; i >= 0; i--) begin
                shbit(w[k][i]);
                e = {e[30:0], w[k][i]};
                chk({31'h0, sdo}, {31'h0, e[31]});
            end
            chk(oe, k ? w[0] : 32'h0);
            rd(4'h0, v, r);
            chk(v, w[k]);
            pins(4'h2);
            pins(4'h3);
            chk(oe, w[k]);
        end
        $display("shift test done");
        for (int k = 0; k < 8; k++) begin
            pins({k[2:0], 1'h1});
            chk(oe, exp_oe(w[1], k[2], k[1], k[0]));
            chk(o, 32'h0);
        end
        $display("output test done");
        @(posedge clk);
        ps <= 1'h0;
        wr(4'h8, 32'h02, r);
        chk({30'h0, r}, 32'h0);
        repeat (8) @(posedge clk);
        #1;
        chk(oe, w[1]);
        rd(4'h4, v, r);
        chk(v, w[1]);
        rd(4'h1, v, r);
        chk({30'h0, r}, 32'h2);
        chk(v, 32'h0);
        wr(4'h4, 32'h0, r);
        chk({30'h0, r}, 32'h2);
        $display("register test done");
        // software shift: one bit per shift-word write, paced apart
        for (int i = 0; i < 8; i++) begin
            v = $urandom;
            b = v[0];
            wr(4'h8, {27'h0, b, 4'h2}, r);
            wr(4'h0, 32'h1, r);
            chk({30'h0, r}, 32'h0);
            repeat (10) @(posedge clk);
            #1;
            e = {e[30:0], b};
            chk({31'h0, sdo}, {31'h0, e[31]});
        end
        rd(4'h0, v, r);
        chk(v, e);
        chk(oe, exp_oe(e, 1'b0, 1'b0, 1'b1));
        rd(4'hc, v, r);
        chk(v, {26'h0, 1'b0, b, 4'h2});
        $display("software shift test done");
        report_and_stop;
    end
endmodule // test_led_head_driver
`default_nettype wire
